//--- design/tmc_consts.vh
// constants for the timer main counter block
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH
`define TMC_OFS_CNT_HI 12'h000
`define TMC_OFS_CNT_LO 12'h004
`define TMC_OFS_MOD_HI 12'h008
`define TMC_OFS_MOD_LO 12'h00C
`define TMC_OFS_CTRL 12'h010
`define TMC_OFS_STAT 12'h014
`define TMC_OFS_CLR 12'h018
`define TMC_OFS_IEN 12'h01C
`define TMC_OFS_PRE 12'h020
`define TMC_CTRL_EN 0
`define TMC_CTRL_CAS 1
`define TMC_STAT_OVF 0
`define TMC_ZERO16 16'h0000
`define TMC_ONE16 16'h0001
`define TMC_MAX16 16'hFFFF
`define TMC_ZERO8 8'h00
`define TMC_ZERO32 32'h00000000
`endif

//--- design/tmc_prescaler.v
// counting clock enable divider for the timer main counter
`timescale 1ns/100ps
`include "tmc_consts.vh"
module tmc_prescaler (
   input wire pclk,        // system clock
   input wire presetn,     // async reset, active low
   input wire [7:0] div,   // divide ratio minus one
   input wire clr,         // restart the divider
   output reg tick         // one-cycle counting enable
);
   reg [7:0] cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         tick <= 1'b0;
      end else if (clr) begin
         cnt <= 8'h00;
         tick <= 1'b0;
      end else if (cnt >= div) begin
         cnt <= 8'h00;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule // tmc_prescaler

//--- design/tmc_main_counter.v
// timer main counter with modulus, center-align, overflow irq and apb
// Operation
// - center-aligned: count up from zero to modulus, then down to zero, repeat.
// - zero and terminal count each last exactly one counting clock.
// - irq enable 0 gives no interrupt; 1 gives level irq while flag set.
// - without modulus, count through 0xFFFF and wrap, setting the flag.
// - with modulus, wrap to zero after modulus, flag set on that wrap.
// - up/down: flag set stepping from modulus down to next lower value.
// - counter is 16 bits with one overflow flag and one enable.
// - reading either count byte latches both bytes into a holding buffer.
// - while buffer pending, keep counting; reads return buffer until both read.
// - writing either count byte resets the counter, whatever the data.
// - such write also clears the coherency state and releases the buffer.
// - center-align select chooses up/down; when 0 up-counting applies.
`timescale 1ns/100ps
`include "tmc_consts.vh"
module tmc_main_counter (
   input wire pclk,            // system clock, 20 MHz
   input wire presetn,         // async reset, active low
   input wire psel,            // apb select
   input wire penable,         // apb enable
   input wire pwrite,          // apb direction
   input wire [11:0] paddr,    // apb byte address
   input wire [31:0] pwdata,   // apb write data
   output wire pready,         // apb ready, always high
   output reg [31:0] prdata,   // apb read data
   output wire pslverr,        // apb error on unmapped address
   output wire irq,            // overflow interrupt level
   output reg [15:0] count,    // live counter value
   output wire count_down      // counting direction, 1 while down
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg [15:0] modulus;
   reg enable;
   reg center_align_select;
   reg [7:0] prescale;
   reg overflow_flag;
   reg overflow_irq_enable;
   reg down;
   reg [15:0] hold;
   reg [15:0] snap;
   reg hold_valid;
   reg hi_read;
   reg lo_read;
   reg [15:0] next_count;
   reg next_down;
   reg wrap_event;
   wire tick;
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   function is_map;
      input [11:0] a;
      begin
         is_map = (a == `TMC_OFS_CNT_HI) || (a == `TMC_OFS_CNT_LO) ||
                  (a == `TMC_OFS_MOD_HI) || (a == `TMC_OFS_MOD_LO) ||
                  (a == `TMC_OFS_CTRL) || (a == `TMC_OFS_STAT) ||
                  (a == `TMC_OFS_CLR) || (a == `TMC_OFS_IEN) ||
                  (a == `TMC_OFS_PRE);
      end
   endfunction
   wire cnt_wr = wr & ((paddr == `TMC_OFS_CNT_HI) | (paddr == `TMC_OFS_CNT_LO));
   wire rd_hi = rd & (paddr == `TMC_OFS_CNT_HI);
   wire rd_lo = rd & (paddr == `TMC_OFS_CNT_LO);
   assign pready = 1'b1;
   assign pslverr = acc & ~is_map(paddr);
   assign count_down = down;
   assign irq = overflow_irq_enable & overflow_flag;
   // ------------------------------------------------------------
   // counting clock
   // ------------------------------------------------------------
   tmc_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .div(prescale),
      .clr(cnt_wr),
      .tick(tick)
   );
   // ------------------------------------------------------------
   // next count
   // ------------------------------------------------------------
   // a modulus of zero means free running through 0xFFFF
   wire [15:0] limit = (modulus == `TMC_ZERO16) ? `TMC_MAX16 : modulus;
   always @* begin
      next_count = count;
      next_down = down;
      wrap_event = 1'b0;
      if (center_align_select) begin
         if (down) begin
            if (count == `TMC_ZERO16) begin
               next_down = 1'b0;
               next_count = count + `TMC_ONE16;
            end else begin
               next_count = count - `TMC_ONE16;
            end
         end else if (count >= limit) begin
            next_down = 1'b1;
            next_count = count - `TMC_ONE16;
            wrap_event = 1'b1;
         end else begin
            next_count = count + `TMC_ONE16;
         end
      end else begin
         next_down = 1'b0;
         if (count >= limit) begin
            next_count = `TMC_ZERO16;
            wrap_event = 1'b1;
         end else begin
            next_count = count + `TMC_ONE16;
         end
      end
   end
   // ------------------------------------------------------------
   // counter and flag
   // ------------------------------------------------------------
   wire clr_ovf = wr & (paddr == `TMC_OFS_CLR) & pwdata[`TMC_STAT_OVF];
   wire step = enable & tick;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= `TMC_ZERO16;
         down <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         if (cnt_wr) begin
            count <= `TMC_ZERO16;
            down <= 1'b0;
         end else if (step) begin
            count <= next_count;
            down <= next_down;
         end
         // set wins over a clear in the same cycle
         if (step & ~cnt_wr & wrap_event)
            overflow_flag <= 1'b1;
         else if (clr_ovf)
            overflow_flag <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // read coherency buffer
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold <= `TMC_ZERO16;
         hold_valid <= 1'b0;
         hi_read <= 1'b0;
         lo_read <= 1'b0;
      end else if (cnt_wr) begin
         hold_valid <= 1'b0;
         hi_read <= 1'b0;
         lo_read <= 1'b0;
      end else if (rd_hi | rd_lo) begin
         if (!hold_valid) begin
            // latch the value already returned at setup, so both bytes agree
            hold <= snap;
            hold_valid <= 1'b1;
            hi_read <= rd_hi;
            lo_read <= rd_lo;
         end else if ((rd_hi | hi_read) & (rd_lo | lo_read)) begin
            hold_valid <= 1'b0;
            hi_read <= 1'b0;
            lo_read <= 1'b0;
         end else begin
            hi_read <= hi_read | rd_hi;
            lo_read <= lo_read | rd_lo;
         end
      end
   end
   wire [15:0] view = hold_valid ? hold : count;
   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modulus <= `TMC_ZERO16;
         enable <= 1'b0;
         center_align_select <= 1'b0;
         overflow_irq_enable <= 1'b0;
         prescale <= `TMC_ZERO8;
      end else if (wr) begin
         case (paddr)
            `TMC_OFS_MOD_HI: modulus[15:8] <= pwdata[7:0];
            `TMC_OFS_MOD_LO: modulus[7:0] <= pwdata[7:0];
            `TMC_OFS_CTRL: begin
               enable <= pwdata[`TMC_CTRL_EN];
               center_align_select <= pwdata[`TMC_CTRL_CAS];
            end
            `TMC_OFS_IEN: overflow_irq_enable <= pwdata[`TMC_STAT_OVF];
            `TMC_OFS_PRE: prescale <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   // ------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `TMC_ZERO32;
         snap <= `TMC_ZERO16;
      end else if (psel & ~penable & ~pwrite) begin
         snap <= count;
         case (paddr)
            `TMC_OFS_CNT_HI: prdata <= {24'h000000, view[15:8]};
            `TMC_OFS_CNT_LO: prdata <= {24'h000000, view[7:0]};
            `TMC_OFS_MOD_HI: prdata <= {24'h000000, modulus[15:8]};
            `TMC_OFS_MOD_LO: prdata <= {24'h000000, modulus[7:0]};
            `TMC_OFS_CTRL: prdata <= {30'h00000000, center_align_select, enable};
            `TMC_OFS_STAT: prdata <= {31'h00000000, overflow_flag};
            `TMC_OFS_IEN: prdata <= {31'h00000000, overflow_irq_enable};
            `TMC_OFS_PRE: prdata <= {24'h000000, prescale};
            default: prdata <= `TMC_ZERO32;
         endcase
      end
   end
endmodule // tmc_main_counter

//--- tb/tmc_main_counter_properties.sv
// checker for the timer main counter
`timescale 1ns/100ps
module tmc_main_counter_properties (
   input wire pclk, // clock
   input wire presetn, // reset
   input wire psel, // select
   input wire penable, // enable
   input wire pwrite, // write
   input wire [11:0] paddr, // address
   input wire pready, // ready
   input wire [31:0] prdata, // read data
   input wire pslverr, // error
   input wire irq, // interrupt
   input wire [15:0] count, // counter
   input wire count_down // direction
);
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_high_a: assert property (pready) else $error("pready low");
   cnt_clear_a: assert property (wr && (paddr == 12'h000 || paddr == 12'h004)
      |=> count == 16'h0000) else $error("count not cleared");
   step_up_a: assert property ($changed(count) && !count_down
      |-> count == $past(count) + 16'h0001 || count == 16'h0000) else $error("bad up step");
   step_down_a: assert property ($changed(count) && count_down
      |-> count == $past(count) - 16'h0001 || count == 16'h0000) else $error("bad down step");
   irq_rise_a: assert property ($rose(irq) |-> count == 16'h0000 || count_down
      || $past(wr && paddr == 12'h01C)) else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(irq)
      |-> $past(wr && (paddr == 12'h018 || paddr == 12'h01C))) else $error("irq fell alone");
   err_map_a: assert property (acc && paddr[1:0] == 2'b00
      |-> pslverr == (paddr > 12'h020)) else $error("pslverr wrong");
   rdata_hold_a: assert property (acc && !pwrite |=> $stable(prdata)) else $error("prdata moved");
   cover property ($rose(irq));
   cover property ($rose(count_down));
   cover property (acc && pslverr);
endmodule // tmc_main_counter_properties

bind tmc_main_counter tmc_main_counter_properties i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .irq(irq), .count(count), .count_down(count_down));

//--- tb/tmc_main_counter_tb_top.sv
// self-checking bench for the timer main counter
`timescale 1ns/100ps
`define TMC_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tmc_main_counter_tb_top;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rnd = 32'h3C62;
   reg [32:0] note;
   reg [32:0] notes[$];
   wire pready, pslverr, irq, count_down;
   wire [31:0] prdata;
   wire [15:0] count;
   int n_fail = 0, n_compared = 0;
   tmc_main_counter i_tmc_main_counter (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .irq(irq), .count(count), .count_down(count_down));
   initial forever #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         note = notes.pop_front();
         `TMC_CHK({pslverr, prdata}, note)
      end
   end
   function automatic [31:0] nxt();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction
   task automatic x(input [11:0] a, input w, input [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input [11:0] a, input [32:0] e);
      notes.push_back(e);
      x(a, 1'b0, 32'h0);
   endtask
   // enabled for exactly 0x123 counting clocks
   task automatic run;
      x(12'h010, 1'b1, 32'h1);
      repeat (288) @(posedge pclk);
      x(12'h010, 1'b1, 32'h0);
   endtask
   task automatic test_done;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      x(12'h020, 1'b1, 32'h0);
      run;
      rd(12'h004, 33'h23);
      x(12'h000, 1'b1, nxt());
      rd(12'h000, 33'h0);
      rd(12'h004, 33'h0);
      run;
      rd(12'h000, 33'h1);
      x(12'h010, 1'b1, 32'h1);
      rd(12'h000, 33'h1);
      x(12'h010, 1'b1, 32'h0);
      rd(12'h004, 33'h23);
      x(12'h040, 1'b1, nxt());
      rd(12'h040, 33'h100000000);
      rd(12'h018, 33'h0);
      $display("coherency test done");
      x(12'h00C, 1'b1, 32'h5);
      x(12'h004, 1'b1, nxt());
      x(12'h010, 1'b1, 32'h1);
      repeat (20) @(posedge pclk);
      `TMC_CHK(irq, 1'b0)
      rd(12'h014, 33'h1);
      x(12'h01C, 1'b1, 32'h1);
      `TMC_CHK(irq, 1'b1)
      x(12'h010, 1'b1, 32'h0);
      x(12'h018, 1'b1, 32'h1);
      `TMC_CHK(irq, 1'b0)
      rd(12'h014, 33'h0);
      x(12'h00C, 1'b1, 32'h0);
      x(12'h004, 1'b1, nxt());
      x(12'h010, 1'b1, 32'h1);
      repeat (65500) @(posedge pclk);
      rd(12'h014, 33'h0);
      repeat (60) @(posedge pclk);
      rd(12'h014, 33'h1);
      x(12'h010, 1'b1, 32'h0);
      x(12'h00C, 1'b1, 32'h5);
      x(12'h004, 1'b1, nxt());
      x(12'h018, 1'b1, 32'h1);
      rd(12'h014, 33'h0);
      x(12'h010, 1'b1, 32'h3);
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      `TMC_CHK({count_down, count}, 17'h10004)
      repeat (40) @(posedge pclk);
      rd(12'h014, 33'h1);
      $display("overflow test done");
      test_done;
   end
   initial begin
      #4000000;
      n_fail++;
      test_done;
   end
endmodule // tmc_main_counter_tb_top
